// *** core/pwmo_pkg.sv ***
// Constants shared by the port with memory-bus override
package pwmo_pkg;

    localparam int PWMO_DATA_W = 8;
    localparam int PWMO_ADDR_W = 3;

    // Register map
    localparam logic [PWMO_ADDR_W-1:0] PWMO_OFS_PIN_LEVEL = 3'h0;
    localparam logic [PWMO_ADDR_W-1:0] PWMO_OFS_LATCH     = 3'h1;
    localparam logic [PWMO_ADDR_W-1:0] PWMO_OFS_DIRECTION = 3'h2;
    localparam logic [PWMO_ADDR_W-1:0] PWMO_OFS_NEIGHBOUR = 3'h3;
    localparam logic [PWMO_ADDR_W-1:0] PWMO_OFS_MEMCTL    = 3'h4;

    // Field positions
    localparam int PWMO_EXT_BUS_DISABLE_BIT = 7;
    localparam int PWMO_PULLUP_GLOBAL_BIT   = 5;

    // Reset values
    localparam logic [PWMO_DATA_W-1:0] PWMO_DIR_RESET       = 8'hff;
    localparam logic [PWMO_DATA_W-1:0] PWMO_LATCH_RESET     = 8'h00;
    localparam logic [PWMO_DATA_W-1:0] PWMO_NEIGHBOUR_RESET = 8'h00;
    localparam logic [PWMO_DATA_W-1:0] PWMO_MEMCTL_RESET    = 8'h80;
    localparam logic [PWMO_DATA_W-1:0] PWMO_ALL_ZERO        = 8'h00;
    localparam logic [PWMO_DATA_W-1:0] PWMO_ALL_ONE         = 8'hff;

    // Memory-bus control function on each pin
    localparam int PWMO_PIN_ADDR_LATCH  = 0;
    localparam int PWMO_PIN_OUT_ENABLE  = 1;
    localparam int PWMO_PIN_WRITE_LOW   = 2;
    localparam int PWMO_PIN_WRITE_HIGH  = 3;
    localparam int PWMO_PIN_BYTE_ADDR0  = 4;
    localparam int PWMO_PIN_CHIP_ENABLE = 5;
    localparam int PWMO_PIN_LOWER_BYTE  = 6;
    localparam int PWMO_PIN_UPPER_BYTE  = 7;

    // Who owns the pins
    typedef enum logic [1:0] {
        PWMO_OWN_GPIO   = 2'b01,
        PWMO_OWN_MEMBUS = 2'b10
    } pwmo_owner_type;

endpackage

// *** core/pwmo_pin_if.sv ***
// Pin control bundle between the register side and the pad logic
`timescale 1ns/1ps
interface pwmo_pin_if;
    logic [pwmo_pkg::PWMO_DATA_W-1:0] direction;
    logic [pwmo_pkg::PWMO_DATA_W-1:0] latch;
    logic [pwmo_pkg::PWMO_DATA_W-1:0] memCtrl;
    logic                             busOwned;
    logic                             pullGlobal;
    logic                             present;

    modport ctrl (output direction, latch, memCtrl, busOwned, pullGlobal, present);
    modport pad  (input  direction, latch, memCtrl, busOwned, pullGlobal, present);
endinterface

// *** core/pwmo_pad_drive.sv ***
// Output value and output enable of the eight pads
`timescale 1ns/1ps
module pwmo_pad_drive
    import pwmo_pkg::*;
(
    input  logic                   clk,
    input  logic                   reset_n,
    pwmo_pin_if.pad                pins,
    output logic [PWMO_DATA_W-1:0] padOut,
    output logic [PWMO_DATA_W-1:0] padOe
);

    // Memory bus wins over the direction bits; absent port never drives
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            padOut <= PWMO_ALL_ZERO;
            padOe  <= PWMO_ALL_ZERO;
        end
        else if (!pins.present)
        begin
            padOut <= PWMO_ALL_ZERO;
            padOe  <= PWMO_ALL_ZERO;
        end
        else if (pins.busOwned)
        begin
            padOut <= pins.memCtrl;                     // [RULE_10]
            padOe  <= PWMO_ALL_ONE;                     // [RULE_05] [RULE_11]
        end
        else
        begin
            padOut <= pins.latch;                       // [RULE_02]
            padOe  <= ~pins.direction;                  // [RULE_02]
        end
    end

endmodule // pwmo_pad_drive

// *** core/pwmo_pullup_ctrl.sv ***
// Weak pull-up enables of the eight pads
`timescale 1ns/1ps
module pwmo_pullup_ctrl
    import pwmo_pkg::*;
(
    input  logic                   clk,
    input  logic                   reset_n,
    pwmo_pin_if.pad                pins,
    output logic [PWMO_DATA_W-1:0] padPullup
);

    // Registered like the drive path so pull-up and driver never overlap
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            padPullup <= PWMO_ALL_ZERO;                 // [RULE_09]
        else if (!pins.present || !pins.pullGlobal || pins.busOwned)
            padPullup <= PWMO_ALL_ZERO;                 // [RULE_07]
        else
            padPullup <= pins.direction;                // [RULE_06] [RULE_08]
    end

endmodule // pwmo_pullup_ctrl

// *** core/pwmo_port.sv ***
// Eight-pin I/O port whose pins the memory bus can take over
//
// Operation
// RULE_01 - The port has eight two-way pins, one per bit of the pin level register.
// RULE_02 - Direction bit 0 drives the pin from its latch bit, 1 makes it a readable input.
// RULE_03 - After any reset every pin is an input.
// RULE_04 - Clearing the external bus disable bit hands all eight pins to the memory bus.
// RULE_05 - While the memory bus owns the pins the direction bits are ignored.
// RULE_06 - Every pin has a weak pull-up to hold inputs at a known level.
// RULE_07 - Clearing the global pull-up bit of the neighbour register turns all pull-ups off.
// RULE_08 - A pin configured as output has its pull-up switched off.
// RULE_09 - After any reset the pull-ups are off.
// RULE_10 - Bus mode maps pins 0..7 to latch, read, write low, write high, byte address, chip, lower and upper byte enables.
// RULE_11 - Each memory-bus function overrides ordinary I/O regardless of direction.
// RULE_12 - Writing either the pin level or the latch register loads the output latches.
// RULE_13 - In the small variant the port registers and pull-up bit are absent and read zero.
// RULE_14 - The latch register reads back latched values, the pin level register the pins.
`timescale 1ns/1ps
module pwmo_port
    import pwmo_pkg::*;
#(
    parameter bit PORT_PRESENT = 1'b1
)
(
    input  logic                   clk,
    input  logic                   reset_n,
    input  logic [PWMO_ADDR_W-1:0] regAddr,
    input  logic [PWMO_DATA_W-1:0] regWriteData,
    input  logic                   regWrite,
    input  logic                   regRead,
    output logic [PWMO_DATA_W-1:0] regReadData,
    input  logic [PWMO_DATA_W-1:0] memCtrl,
    output logic                   memBusOwned,
    input  logic [PWMO_DATA_W-1:0] padIn,
    output logic [PWMO_DATA_W-1:0] padOut,
    output logic [PWMO_DATA_W-1:0] padOe,
    output logic [PWMO_DATA_W-1:0] padPullup
);

    // Offsets that belong to the port itself and vanish in the small variant
    function automatic logic isPortReg(input logic [PWMO_ADDR_W-1:0] addr);
        isPortReg = (addr == PWMO_OFS_PIN_LEVEL) || (addr == PWMO_OFS_LATCH)
                 || (addr == PWMO_OFS_DIRECTION);
    endfunction

    // Either data register loads the latch
    function automatic logic isLatchWrite(input logic [PWMO_ADDR_W-1:0] addr);
        isLatchWrite = (addr == PWMO_OFS_PIN_LEVEL) || (addr == PWMO_OFS_LATCH);
    endfunction

    logic [PWMO_DATA_W-1:0] latch;
    logic [PWMO_DATA_W-1:0] direction;
    logic [PWMO_DATA_W-1:0] neighbour;
    logic [PWMO_DATA_W-1:0] memoryCtl;
    pwmo_owner_type         owner;
    pwmo_owner_type         next_owner;
    logic [PWMO_DATA_W-1:0] next_readData;
    logic                   memCtlWrite;
    logic                   afterReset;

    pwmo_pin_if pins ();

    assign memCtlWrite = regWrite && (regAddr == PWMO_OFS_MEMCTL);

    // Output latch
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            latch <= PWMO_LATCH_RESET;
        else if (PORT_PRESENT && regWrite && isLatchWrite(regAddr))
            latch <= regWriteData;                      // [RULE_12]
    end

    // Direction bits; all inputs out of reset
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            direction <= PWMO_DIR_RESET;                // [RULE_03]
        else if (PORT_PRESENT && regWrite && (regAddr == PWMO_OFS_DIRECTION))
            direction <= regWriteData;
    end

    // Neighbour register; only the pull-up bit matters to this port
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            neighbour <= PWMO_NEIGHBOUR_RESET;          // [RULE_09]
        else if (regWrite && (regAddr == PWMO_OFS_NEIGHBOUR))
            neighbour <= regWriteData;
    end

    // Memory interface control; bus disabled out of reset
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            memoryCtl <= PWMO_MEMCTL_RESET;
        else if (memCtlWrite)
            memoryCtl <= regWriteData;
    end

    // Ownership follows the disable bit in the same edge it is written
    always_comb
    begin
        next_owner = owner;
        if (memCtlWrite)
        begin
            if (regWriteData[PWMO_EXT_BUS_DISABLE_BIT])
                next_owner = PWMO_OWN_GPIO;
            else
                next_owner = PWMO_OWN_MEMBUS;           // [RULE_04]
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            owner <= PWMO_OWN_GPIO;
        else
        begin
            case (owner)
                PWMO_OWN_GPIO:   owner <= next_owner;
                PWMO_OWN_MEMBUS: owner <= next_owner;
                default:         owner <= PWMO_OWN_GPIO;
            endcase
        end
    end

    // Read mux; absent port registers and the pull-up bit read zero
    always_comb
    begin
        next_readData = PWMO_ALL_ZERO;
        if (regRead)
        begin
            case (regAddr)
                PWMO_OFS_PIN_LEVEL: next_readData = padIn;      // [RULE_01] [RULE_14]
                PWMO_OFS_LATCH:     next_readData = latch;      // [RULE_14]
                PWMO_OFS_DIRECTION: next_readData = direction;
                PWMO_OFS_NEIGHBOUR: next_readData = neighbour;
                PWMO_OFS_MEMCTL:    next_readData = memoryCtl;
                default:            next_readData = PWMO_ALL_ZERO;
            endcase
            if (!PORT_PRESENT && isPortReg(regAddr))
                next_readData = PWMO_ALL_ZERO;          // [RULE_13]
            if (!PORT_PRESENT && (regAddr == PWMO_OFS_NEIGHBOUR))
                next_readData[PWMO_PULLUP_GLOBAL_BIT] = 1'b0;   // [RULE_13]
        end
    end

    // Data stands only in the cycle after the read strobe
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            regReadData <= PWMO_ALL_ZERO;
        else
            regReadData <= next_readData;
    end

    assign pins.direction  = direction;
    assign pins.latch      = latch;
    assign pins.memCtrl    = memCtrl;
    assign pins.busOwned   = PORT_PRESENT && (owner == PWMO_OWN_MEMBUS);   // [RULE_04]
    assign pins.pullGlobal = neighbour[PWMO_PULLUP_GLOBAL_BIT];            // [RULE_07]
    assign pins.present    = PORT_PRESENT;
    assign memBusOwned     = pins.busOwned;

    pwmo_pad_drive u_drive
    (
        .clk     (clk),
        .reset_n (reset_n),
        .pins    (pins.pad),
        .padOut  (padOut),
        .padOe   (padOe)
    );

    pwmo_pullup_ctrl u_pullup
    (
        .clk       (clk),
        .reset_n   (reset_n),
        .pins      (pins.pad),
        .padPullup (padPullup)
    );

    // Marks the first edge after reset release, for checking only
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            afterReset <= 1'b1;
        else
            afterReset <= 1'b0;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    pin_level_read_a: assert property ( // [RULE_01]
        (regRead && regAddr == PWMO_OFS_PIN_LEVEL && PORT_PRESENT)
            |=> (regReadData == $past(padIn)))
        else $error("pin level read does not return the sampled pins");

    gpio_drive_a: assert property ( // [RULE_02]
        (!pins.busOwned && PORT_PRESENT)
            |=> (padOe == ~$past(direction)) && (padOut == $past(latch)))
        else $error("pad drive does not follow direction and latch");

    reset_input_a: assert property ( // [RULE_03]
        afterReset |-> (padOe == PWMO_ALL_ZERO) && (direction == PWMO_DIR_RESET))
        else $error("pins are not inputs after reset");

    bus_takeover_a: assert property ( // [RULE_04]
        (memCtlWrite && !regWriteData[PWMO_EXT_BUS_DISABLE_BIT] && PORT_PRESENT)
            |=> pins.busOwned ##1 (padOe == PWMO_ALL_ONE))
        else $error("clearing the disable bit did not hand the pins over");

    dir_override_a: assert property ( // [RULE_05]
        (pins.busOwned && $changed(direction)) |=> (padOe == PWMO_ALL_ONE))
        else $error("direction bits act while the memory bus owns the pins");

    bus_pin_map_a: assert property ( // [RULE_10]
        pins.busOwned |=> (padOut[PWMO_PIN_CHIP_ENABLE] == $past(memCtrl[PWMO_PIN_CHIP_ENABLE]))
            && (padOut == $past(memCtrl)))
        else $error("memory bus functions are not on their pins");

    bus_priority_a: assert property ( // [RULE_11]
        (pins.busOwned && direction != PWMO_ALL_ZERO)
            |=> (padOe == PWMO_ALL_ONE) && (padOut != $past(latch) || $past(memCtrl == latch)))
        else $error("ordinary I/O overrides a memory bus function");

    pull_global_a: assert property ( // [RULE_07]
        !pins.pullGlobal |=> (padPullup == PWMO_ALL_ZERO))
        else $error("pull-ups on while the global enable is clear");

    pull_input_a: assert property ( // [RULE_06]
        (pins.pullGlobal && !pins.busOwned && PORT_PRESENT)
            |=> (padPullup == $past(direction)))
        else $error("input pins lack their pull-up");

    pull_output_off_a: assert property ( // [RULE_08]
        (padPullup & padOe) == PWMO_ALL_ZERO)
        else $error("pull-up on a driven pin");

    pull_reset_a: assert property ( // [RULE_09]
        afterReset |-> (padPullup == PWMO_ALL_ZERO) && !neighbour[PWMO_PULLUP_GLOBAL_BIT])
        else $error("pull-ups not off after reset");

    latch_write_a: assert property ( // [RULE_12]
        (regWrite && isLatchWrite(regAddr) && PORT_PRESENT)
            |=> (latch == $past(regWriteData)))
        else $error("data register write did not load the latch");

    small_zero_a: assert property ( // [RULE_13]
        (!PORT_PRESENT && regRead && isPortReg(regAddr))
            |=> (regReadData == PWMO_ALL_ZERO))
        else $error("absent port register reads nonzero");

    latch_read_a: assert property ( // [RULE_14]
        (regRead && regAddr == PWMO_OFS_LATCH && PORT_PRESENT)
            |=> (regReadData == $past(latch)))
        else $error("latch read does not return the latch");

    // Register file, ownership and small variant checks
    read_idle_a: assert property ( // [RULE_14]
        !regRead |=> (regReadData == PWMO_ALL_ZERO))
        else $error("read data not zero outside the read answer cycle");

    dir_write_a: assert property ( // [RULE_02]
        (regWrite && regAddr == PWMO_OFS_DIRECTION && PORT_PRESENT)
            |=> (direction == $past(regWriteData)))
        else $error("direction write did not load the direction bits");

    dir_read_a: assert property ( // [RULE_02]
        (regRead && regAddr == PWMO_OFS_DIRECTION && PORT_PRESENT)
            |=> (regReadData == $past(direction)))
        else $error("direction read does not return the direction bits");

    neighbour_write_a: assert property ( // [RULE_07]
        (regWrite && regAddr == PWMO_OFS_NEIGHBOUR)
            |=> (neighbour == $past(regWriteData)))
        else $error("neighbour write did not load the register");

    neighbour_read_a: assert property ( // [RULE_07]
        (regRead && regAddr == PWMO_OFS_NEIGHBOUR && PORT_PRESENT)
            |=> (regReadData == $past(neighbour)))
        else $error("neighbour read does not return the register");

    memctl_read_a: assert property ( // [RULE_04]
        (regRead && regAddr == PWMO_OFS_MEMCTL)
            |=> (regReadData == $past(memoryCtl)))
        else $error("memory control read does not return the register");

    bus_release_a: assert property ( // [RULE_04]
        (memCtlWrite && regWriteData[PWMO_EXT_BUS_DISABLE_BIT]) |=> !pins.busOwned)
        else $error("setting the disable bit did not release the pins");

    owner_legal_a: assert property ( // [RULE_04]
        $onehot(owner))
        else $error("pin owner state is not one-hot");

    reset_owner_a: assert property ( // [RULE_03]
        afterReset |-> !pins.busOwned && memoryCtl[PWMO_EXT_BUS_DISABLE_BIT])
        else $error("memory bus owns the pins after reset");

    bus_pull_off_a: assert property ( // [RULE_08]
        pins.busOwned |=> (padPullup == PWMO_ALL_ZERO))
        else $error("pull-ups on while the memory bus drives the pins");

    bus_all_out_a: assert property ( // [RULE_11]
        pins.busOwned |=> (padOe == PWMO_ALL_ONE))
        else $error("a pin leaves the memory bus while it owns the pins");

    bus_latch_load_a: assert property ( // [RULE_12]
        (pins.busOwned && regWrite && isLatchWrite(regAddr) && PORT_PRESENT)
            |=> (latch == $past(regWriteData)))
        else $error("latch write lost while the memory bus owns the pins");

    small_quiet_a: assert property ( // [RULE_13]
        !PORT_PRESENT |-> (padOe == PWMO_ALL_ZERO) && (padPullup == PWMO_ALL_ZERO)
            && !pins.busOwned)
        else $error("absent port drives or pulls its pins");

    small_pull_bit_a: assert property ( // [RULE_13]
        (!PORT_PRESENT && regRead && regAddr == PWMO_OFS_NEIGHBOUR)
            |=> !regReadData[PWMO_PULLUP_GLOBAL_BIT])
        else $error("absent pull-up bit reads nonzero");

    small_regs_hold_a: assert property ( // [RULE_13]
        !PORT_PRESENT |=> $stable(latch) && $stable(direction))
        else $error("absent port registers took a write");

    // Main scenarios
    bus_takeover_c: cover property (
        memCtlWrite && !regWriteData[PWMO_EXT_BUS_DISABLE_BIT] ##2 padOe == PWMO_ALL_ONE);

    bus_release_c: cover property (
        pins.busOwned ##1 !pins.busOwned ##1 padOe == ~direction);

    mixed_dir_c: cover property (
        padOe != PWMO_ALL_ZERO && padPullup != PWMO_ALL_ZERO);

    latch_readback_c: cover property (
        regWrite && regAddr == PWMO_OFS_PIN_LEVEL ##2 regRead && regAddr == PWMO_OFS_LATCH);

    bus_dir_write_c: cover property (
        pins.busOwned && regWrite && regAddr == PWMO_OFS_DIRECTION);

endmodule // pwmo_port

// *** dv/pwmo_board_model.sv ***
// Board-side model of the eight pins: outside drivers, pull-ups and floating lines
`timescale 1ns/1ps
module pwmo_board_model
    import pwmo_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic [PWMO_DATA_W-1:0] padOut,
    input  wire logic [PWMO_DATA_W-1:0] padOe,
    input  wire logic [PWMO_DATA_W-1:0] padPullup,
    input  wire logic [PWMO_DATA_W-1:0] extVal,
    input  wire logic [PWMO_DATA_W-1:0] extOe,
    output logic      [PWMO_DATA_W-1:0] padIn
);
    logic [PWMO_DATA_W-1:0] floatBits = 8'h5a;

    // An undriven line without pull-up must never look like a stable value
    always_ff @(posedge clk)
    begin
        floatBits <= ~floatBits;
    end

    always_comb
    begin
        for (int i = 0; i < PWMO_DATA_W; i++)
        begin
            if (padOe[i])
                padIn[i] = padOut[i];
            else if (extOe[i])
                padIn[i] = extVal[i];
            else if (padPullup[i])
                padIn[i] = 1'b1;
            else
                padIn[i] = floatBits[i];
        end
    end
endmodule // pwmo_board_model

// *** dv/pwmo_port_tb_top.sv ***
// Self-checking testbench of the port with memory-bus override
`timescale 1ns/1ps
module pwmo_port_tb_top
    import pwmo_pkg::*;
;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [2:0] regAddr = 3'h0;
    logic [7:0] regWriteData = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [7:0] memCtrl = 8'h00;
    logic [7:0] extVal = 8'h00;
    logic [7:0] extOe = 8'h00;
    logic [7:0] regReadData, padIn, padOut, padOe, padPullup;
    logic [7:0] smallRead, smallOe, smallPullup;
    logic memBusOwned, smallOwned;
    int errors = 0;
    int samplesChecked = 0;
    logic [7:0] d, dir, lat, m, xo;
    logic g;
    logic [2:0] ra [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
    logic [7:0] rv [6] = '{8'h00, 8'hff, 8'h00, 8'h80, 8'h00, 8'h00};

    initial
    begin
        forever #50 clk = ~clk;
    end

    pwmo_port pwmo_port_i (.clk(clk), .reset_n(reset_n), .regAddr(regAddr),
        .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
        .regReadData(regReadData), .memCtrl(memCtrl), .memBusOwned(memBusOwned),
        .padIn(padIn), .padOut(padOut), .padOe(padOe), .padPullup(padPullup));
    // Small package variant sees the same register traffic
    pwmo_port #(.PORT_PRESENT(1'b0)) pwmo_port_small_i (.clk(clk), .reset_n(reset_n),
        .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite),
        .regRead(regRead), .regReadData(smallRead), .memCtrl(memCtrl),
        .memBusOwned(smallOwned), .padIn(padIn), .padOut(), .padOe(smallOe),
        .padPullup(smallPullup));
    pwmo_board_model pwmo_board_model_i (.clk(clk), .padOut(padOut), .padOe(padOe),
        .padPullup(padPullup), .extVal(extVal), .extOe(extOe), .padIn(padIn));

    function automatic logic [7:0] expPull(input logic [7:0] dr, input logic gl);
        return dr & {8{gl}};
    endfunction

    function automatic logic [7:0] expLevel(input logic [7:0] dr, lt, eo, ev,
                                            input logic gl);
        return (~dr & lt) | (dr & eo & ev) | (dr & ~eo & {8{gl}});
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samplesChecked++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        regAddr <= a;
        regWriteData <= v;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        v = regReadData;
    endtask

    task automatic settle();
        @(posedge clk);
        #1;
    endtask

    task automatic wrap_up();
        if (errors == 0 && samplesChecked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        #(100 * 5000);
        errors++;
        wrap_up();
    end

    initial
    begin
        void'($urandom(43632));
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        check(padOe, 8'h00);
        check(padPullup, 8'h00);
        for (int i = 0; i < 6; i++)
        begin
            rd(ra[i], d);
            check(d, rv[i]);
        end
        wr(3'h3, 8'h20);
        settle();
        check(padPullup, 8'hff);
        rd(3'h0, d);
        check(d, 8'hff);
        wr(3'h1, 8'ha5);
        wr(3'h0, 8'h00);
        rd(3'h1, d);
        check(d, 8'h00);
        wr(3'h0, 8'h3c);
        rd(3'h1, d);
        check(d, 8'h3c);
        for (int i = 0; i < 24; i++)
        begin
            dir = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
            lat = 8'($urandom);
            g = (i < 2) ? 1'b1 : 1'($urandom);
            xo = dir & 8'($urandom);
            wr(3'h2, dir);
            wr(3'h1, lat);
            wr(3'h3, {2'b00, g, 5'h00});
            extOe <= xo;
            extVal <= 8'($urandom);
            settle();
            check(padOe, ~dir);
            check(padOut & ~dir, lat & ~dir);
            check(padPullup, expPull(dir, g));
            check(smallOe | smallPullup, 8'h00);
            rd(3'h0, d);
            check(d & (~dir | xo | {8{g}}), expLevel(dir, lat, xo, extVal, g));
            check(smallRead, 8'h00);
            rd(3'h1, d);
            check(d, lat);
            check(smallRead, 8'h00);
        end
        rd(3'h3, d);
        check(smallRead, 8'h00);
        extOe <= 8'h00;
        wr(3'h4, 8'h7f);
        settle();
        check({7'h00, memBusOwned}, 8'h01);
        for (int k = 0; k < 8; k++)
        begin
            wr(3'h2, 8'($urandom));
            m = 8'h01 << k;
            @(posedge clk);
            memCtrl <= m;
            settle();
            check(padOut, m);
            check(padOe, 8'hff);
            check(padPullup, 8'h00);
            check({7'h00, smallOwned}, 8'h00);
        end
        wr(3'h2, 8'h0f);
        wr(3'h4, 8'h80);
        settle();
        check({7'h00, memBusOwned}, 8'h00);
        check(padOe, 8'hf0);
        // Reset while the memory bus owns the pins
        wr(3'h4, 8'h00);
        settle();
        @(posedge clk);
        reset_n <= 1'b0;
        #1;
        check(padOe, 8'h00);
        check(padPullup, 8'h00);
        check({7'h00, memBusOwned}, 8'h00);
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        settle();
        check(padOe, 8'h00);
        rd(3'h4, d);
        check(d, 8'h80);
        wrap_up();
    end
endmodule // pwmo_port_tb_top
